// File: config_master.sv
`default_nettype none

module config_master
   import switch_partition_pkg::*;
(
   input wire logic sys_clk,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata
);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = HSIZE_WORD;
      hwdata = 32'h0000_0000;
   end

   task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= HTRANS_NONSEQ;
      hwrite <= wr;
      hsize <= HSIZE_WORD;
      do @(posedge sys_clk); while (hready !== 1'b1);
      // released address lines toggle so stale values cannot pass
      hsel <= 1'b0;
      htrans <= 2'h0;
      haddr <= ~a;
      hwdata <= wd;
      do @(posedge sys_clk); while (hready !== 1'b1);
      rd = hrdata;
      hwdata <= ~wd;
   endtask : xfer
endmodule : config_master

`default_nettype wire

// File: partition_seq.sv
`default_nettype none

module partition_seq
   import switch_partition_pkg::*;
(
   input wire logic sys_clk,
   input wire logic resetn,
   input wire part_state_e field,
   input wire logic change_req,
   input wire logic clr_started,
   input wire logic clr_done,
   input wire logic ports_busy,
   input wire logic ext_reset,
   input wire logic [TIMER_W-1:0] reset_drain_cycles,
   input wire logic [TIMER_W-1:0] mode_drain_cycles,
   output logic started,
   output logic done,
   output logic busy,
   output logic disable_ports,
   output logic reset_out,
   output logic active_out
);
   seq_state_s r;
   seq_state_s n;
   logic to_active_gated;

   // [RULE18] pin holds back entry into active
   assign to_active_gated = ext_reset && (field == ST_ACTIVE) && (r.from_state != ST_ACTIVE);

   always_comb begin
      n = r;
      n.prev_field = field;
      // [RULE2] outputs follow the control field
      // [RULE3] forced port disable
      n.disable_ports = (field == ST_DISABLED);
      // [RULE4] [RULE6] reset held for as long as selected
      n.reset_out = (field == ST_FRESET) || ext_reset;
      // [RULE7] normal switching only when active
      n.active_out = (field == ST_ACTIVE) && !ext_reset;
      // [RULE21] clears first so a same-cycle set wins
      if (clr_started) begin
         n.started = 1'b0;
      end
      if (clr_done) begin
         n.done = 1'b0;
      end
      unique case (r.phase)
         PH_IDLE: begin
         end
         PH_SETTLE: begin
            // [RULE11] wait out port mode changes
            if (r.count != '0) begin
               n.count = r.count - 1'b1;
            end else if (!ports_busy) begin
               // [RULE10] drain before reset completes
               if (field == ST_FRESET) begin
                  n.phase = PH_DRAIN;
                  n.count = reset_drain_cycles;
               end else begin
                  n.phase = PH_GATE;
               end
            end
         end
         PH_DRAIN: begin
            if (r.count != '0) begin
               n.count = r.count - 1'b1;
            end else begin
               n.phase = PH_GATE;
            end
         end
         PH_GATE: begin
            // [RULE9] [RULE12] done once all effects ended
            if (!to_active_gated && !ports_busy) begin
               n.phase = PH_IDLE;
               n.done = 1'b1;
            end
         end
      endcase
      // [RULE8] [RULE16] a new write restarts the sequence
      if (change_req) begin
         n.phase = PH_SETTLE;
         n.count = mode_drain_cycles;
         n.from_state = r.prev_field;
         n.started = 1'b1;
         n.done = 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         r <= '{phase: PH_IDLE, prev_field: ST_DISABLED, from_state: ST_DISABLED,
                count: '0, started: 1'b0, done: 1'b0, disable_ports: 1'b1,
                reset_out: 1'b0, active_out: 1'b0};
      end else begin
         r <= n;
      end
   end

   assign started = r.started;
   assign done = r.done;
   assign busy = (r.phase != PH_IDLE);
   assign disable_ports = r.disable_ports;
   assign reset_out = r.reset_out;
   assign active_out = r.active_out;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   sequence drain_entry_s;
      (r.phase == PH_SETTLE) ##1 (r.phase == PH_DRAIN);
   endsequence

   property drain_load_p;
      drain_entry_s |-> (r.count == $past(reset_drain_cycles));
   endproperty

   legal_state_a: assert property (field != 2'b11) // RULE1
      else $error("illegal partition state code");
   ports_disable_a: assert property (disable_ports == ($past(field) == ST_DISABLED)) // RULE3
      else $error("port disable does not follow state");
   reset_hold_a: assert property ((field == ST_FRESET) [*2] |-> reset_out) // RULE6
      else $error("reset not held in fundamental reset");
   start_flag_a: assert property (change_req |=> started && !done && busy) // RULE8
      else $error("change start not flagged");
   done_source_a: assert property ($rose(done) |-> $past(r.phase) == PH_GATE) // RULE9
      else $error("done set outside completion step");
   drain_load_a: assert property (drain_load_p) // RULE10
      else $error("drain timer not loaded");
   drain_hold_a: assert property ((r.phase == PH_DRAIN && r.count != '0 && !change_req)
                                  |=> !done && r.phase == PH_DRAIN) // RULE10
      else $error("drain ended early");
   busy_block_a: assert property ((r.phase == PH_SETTLE && r.count == '0 && ports_busy
                                   && !change_req) |=> !done && busy) // RULE11
      else $error("completion ahead of port mode change");
   pin_gate_a: assert property ((r.phase == PH_GATE && to_active_gated && !change_req)
                                |=> !done) // RULE18
      else $error("change to active done under reset pin");
   clear_done_a: assert property ((clr_done && !change_req && r.phase != PH_GATE) |=> !done) // RULE21
      else $error("done not cleared");
endmodule : partition_seq

`default_nettype wire

// File: pin_sync.sv
`default_nettype none

module pin_sync
   import switch_partition_pkg::*;
(
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic [PARTITIONS-1:0] pin_in,
   output logic [PARTITIONS-1:0] pin_out
);
   sync_state_s r;
   sync_state_s n;

   // stage1 feeds stage2 only
   always_comb begin
      n = r;
      n.stage1 = pin_in;
      n.stage2 = r.stage1;
   end

   // idle pin level is high (reset not asserted)
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         r <= '{stage1: '1, stage2: '1};
      end else begin
         r <= n;
      end
   end

   assign pin_out = r.stage2;
endmodule : pin_sync

`default_nettype wire

// File: switch_partition_pkg.sv
// Contract
// [RULE1] partition always in exactly one of three states
// [RULE2] current state comes only from control field
// [RULE3] disabled partition forces attached ports disabled
// [RULE4] fundamental reset state resets partition logic, ports
// [RULE5] registers initialised on entry, stay writable afterwards
// [RULE6] reset held while field selects fundamental reset
// [RULE7] active state runs normal switching
// [RULE8] change start sets change-started status bit
// [RULE9] change finish sets change-done status bit
// [RULE10] changes quick; into reset takes 250 us
// [RULE11] completion waits for attached port mode changes
// [RULE12] done only after every device-wide effect finished
// [RULE13] eeprom changes state only on empty partitions
// [RULE14] eeprom zeroes delay timers, restores them after
// [RULE15] eeprom enables reset pin after all configuration
// [RULE16] software waits completion before next change
// [RULE17] no state change during port mode changes
// [RULE18] reset pin blocks completion of changes to active
// [RULE19] sixteen partitions, each with own registers
// [RULE20] state encoding fixed: disabled 0, reset 1, active 2
// [RULE21] status bits write-one-clear; state write restarts them
`default_nettype none

package switch_partition_pkg;
   localparam int PARTITIONS = 16;
   localparam int IDX_W = 4;
   localparam int CLK_PERIOD_NS = 100;
   localparam int RESET_DRAIN_US = 250;
   localparam int RESET_DRAIN_CYCLES = (RESET_DRAIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETTLE_CYCLES = 4;
   localparam int TIMER_W = 12;
   localparam logic [TIMER_W-1:0] RESET_DRAIN_RST = TIMER_W'(RESET_DRAIN_CYCLES);
   localparam logic [TIMER_W-1:0] MODE_DRAIN_RST = TIMER_W'(SETTLE_CYCLES);

   // byte offsets, one aligned word per register
   localparam logic [7:0] CTRL_BASE = 8'h00;
   localparam logic [7:0] STATUS_BASE = 8'h40;
   localparam logic [7:0] RESET_DRAIN_OFS = 8'h80;
   localparam logic [7:0] MODE_DRAIN_OFS = 8'h84;
   localparam int CTRL_STATE_LSB = 0;
   localparam int STATUS_STARTED_BIT = 0;
   localparam int STATUS_DONE_BIT = 1;
   localparam int STATUS_BUSY_BIT = 2;
   localparam int STATUS_STATE_LSB = 4;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD = 3'h2;

   // [RULE20] fixed state encoding
   typedef enum logic [1:0] {
      ST_DISABLED = 2'b00,
      ST_FRESET = 2'b01,
      ST_ACTIVE = 2'b10
   } part_state_e;

   typedef enum logic [1:0] {
      PH_IDLE = 2'b00,
      PH_SETTLE = 2'b01,
      PH_DRAIN = 2'b10,
      PH_GATE = 2'b11
   } seq_phase_e;

   typedef struct packed {
      seq_phase_e phase;
      part_state_e prev_field;
      part_state_e from_state;
      logic [TIMER_W-1:0] count;
      logic started;
      logic done;
      logic disable_ports;
      logic reset_out;
      logic active_out;
   } seq_state_s;

   typedef struct packed {
      logic [PARTITIONS-1:0] stage1;
      logic [PARTITIONS-1:0] stage2;
   } sync_state_s;

   typedef struct packed {
      part_state_e [PARTITIONS-1:0] field;
      logic [PARTITIONS-1:0] change_req;
      logic [TIMER_W-1:0] reset_drain;
      logic [TIMER_W-1:0] mode_drain;
      logic dp_write;
      logic dp_mapped;
      logic [7:0] dp_addr;
      logic [31:0] rdata;
      logic readyout;
      logic resp;
   } slave_state_s;
endpackage : switch_partition_pkg

`default_nettype wire

// File: switch_partition_state_control.sv
// Decided for this implementation: register access over AHB-Lite and the placing of the registers.
`default_nettype none

module switch_partition_state_control
   import switch_partition_pkg::*;
(
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [PARTITIONS-1:0] partition_reset_in_n,
   input wire logic [PARTITIONS-1:0] port_mode_busy,
   output logic [PARTITIONS-1:0] ports_forced_disabled,
   output logic [PARTITIONS-1:0] partition_reset,
   output logic [PARTITIONS-1:0] partition_active
);
   slave_state_s r;
   slave_state_s n;

   logic [PARTITIONS-1:0] reset_pin_n_sync;
   logic [PARTITIONS-1:0] ext_reset;
   logic [PARTITIONS-1:0] clr_started;
   logic [PARTITIONS-1:0] clr_done;
   logic [PARTITIONS-1:0] started_vec;
   logic [PARTITIONS-1:0] done_vec;
   logic [PARTITIONS-1:0] busy_vec;
   logic addr_phase;
   logic addr_ok;

   pin_sync reset_pin_sync (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .pin_in(partition_reset_in_n),
      .pin_out(reset_pin_n_sync)
   );

   assign ext_reset = ~reset_pin_n_sync;

   // a transfer is taken only when the bus is ready and it is nonseq
   assign addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ);
   // anything but an aligned word in the low page reads zero
   assign addr_ok = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'b00)
                    && (hsize == HSIZE_WORD);

   function automatic logic mapped(input logic [7:0] addr);
      logic hit;
      hit = 1'b0;
      if (addr < STATUS_BASE) begin
         hit = 1'b1;
      end else if (addr < RESET_DRAIN_OFS) begin
         hit = 1'b1;
      end else if (addr == RESET_DRAIN_OFS || addr == MODE_DRAIN_OFS) begin
         hit = 1'b1;
      end
      return hit;
   endfunction : mapped

   function automatic logic [31:0] read_word(input logic [7:0] addr,
                                             input slave_state_s s,
                                             input logic [PARTITIONS-1:0] st,
                                             input logic [PARTITIONS-1:0] dn,
                                             input logic [PARTITIONS-1:0] bz);
      logic [31:0] word;
      logic [IDX_W-1:0] idx;
      word = 32'h00000000;
      idx = addr[IDX_W+1:2];
      if (addr < STATUS_BASE) begin
         word[CTRL_STATE_LSB +: 2] = s.field[idx];
      end else if (addr < RESET_DRAIN_OFS) begin
         // status shows live sequencer state
         word[STATUS_STARTED_BIT] = st[idx];
         word[STATUS_DONE_BIT] = dn[idx];
         word[STATUS_BUSY_BIT] = bz[idx];
         word[STATUS_STATE_LSB +: 2] = s.field[idx];
      end else if (addr == RESET_DRAIN_OFS) begin
         word[TIMER_W-1:0] = s.reset_drain;
      end else if (addr == MODE_DRAIN_OFS) begin
         word[TIMER_W-1:0] = s.mode_drain;
      end
      return word;
   endfunction : read_word

   always_comb begin
      logic [IDX_W-1:0] wr_idx;
      n = r;
      wr_idx = r.dp_addr[IDX_W+1:2];
      clr_started = '0;
      clr_done = '0;
      n.change_req = '0;
      // zero-wait slave, always okay
      n.readyout = 1'b1;
      n.resp = 1'b0;

      // data phase of the previous write
      if (r.dp_write && r.dp_mapped) begin
         if (r.dp_addr < STATUS_BASE) begin
            // [RULE1] reserved code is dropped, state stays legal
            if (hwdata[CTRL_STATE_LSB +: 2] != 2'b11) begin
               // [RULE5] control stays writable in every state
               n.field[wr_idx] = part_state_e'(hwdata[CTRL_STATE_LSB +: 2]);
               n.change_req[wr_idx] = 1'b1;
            end
         end else if (r.dp_addr < RESET_DRAIN_OFS) begin
            // [RULE21] write one to clear status
            clr_started[wr_idx] = hwdata[STATUS_STARTED_BIT];
            clr_done[wr_idx] = hwdata[STATUS_DONE_BIT];
         end else if (r.dp_addr == RESET_DRAIN_OFS) begin
            // [RULE10] drain length is software tunable, zero skips it
            n.reset_drain = hwdata[TIMER_W-1:0];
         end else if (r.dp_addr == MODE_DRAIN_OFS) begin
            n.mode_drain = hwdata[TIMER_W-1:0];
         end
      end

      // address phase
      n.dp_write = 1'b0;
      if (addr_phase) begin
         n.dp_write = hwrite;
         n.dp_addr = haddr[7:0];
         n.dp_mapped = addr_ok && mapped(haddr[7:0]);
         if (!hwrite) begin
            if (addr_ok && mapped(haddr[7:0])) begin
               n.rdata = read_word(haddr[7:0], r, started_vec, done_vec, busy_vec);
            end else begin
               n.rdata = 32'h00000000;
            end
         end
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         r <= '{field: {PARTITIONS{ST_DISABLED}}, change_req: '0,
                reset_drain: RESET_DRAIN_RST, mode_drain: MODE_DRAIN_RST,
                dp_write: 1'b0, dp_mapped: 1'b0, dp_addr: 8'h00,
                rdata: 32'h00000000, readyout: 1'b1, resp: 1'b0};
      end else begin
         r <= n;
      end
   end

   assign hreadyout = r.readyout;
   assign hresp = r.resp;
   assign hrdata = r.rdata;

   // [RULE19] one independent sequencer per partition
   genvar gi;
   generate
      for (gi = 0; gi < PARTITIONS; gi++) begin : g_part
         partition_seq seq (
            .sys_clk(sys_clk),
            .resetn(resetn),
            .field(r.field[gi]),
            .change_req(r.change_req[gi]),
            .clr_started(clr_started[gi]),
            .clr_done(clr_done[gi]),
            .ports_busy(port_mode_busy[gi]),
            .ext_reset(ext_reset[gi]),
            .reset_drain_cycles(r.reset_drain),
            .mode_drain_cycles(r.mode_drain),
            .started(started_vec[gi]),
            .done(done_vec[gi]),
            .busy(busy_vec[gi]),
            .disable_ports(ports_forced_disabled[gi]),
            .reset_out(partition_reset[gi]),
            .active_out(partition_active[gi])
         );

         // [RULE4] reset output tracks the selected state
         part_reset_a: assert property (@(posedge sys_clk) disable iff (!resetn)
            (r.field[gi] == ST_FRESET) |=> partition_reset[gi]) // RULE4
            else $error("partition not held in reset");
         // [RULE7] active only when selected
         part_active_a: assert property (@(posedge sys_clk) disable iff (!resetn)
            partition_active[gi] |-> $past(r.field[gi]) == ST_ACTIVE) // RULE7
            else $error("partition active in wrong state");
      end
   endgenerate

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   bus_okay_a: assert property (hreadyout && !hresp)
      else $error("slave stalled or answered error");
   // [RULE5] field write lands and starts a change
   field_write_a: assert property ((r.dp_write && r.dp_mapped && r.dp_addr < STATUS_BASE
                                    && hwdata[1:0] != 2'b11)
                                   |=> r.field[$past(r.dp_addr[5:2])] == $past(hwdata[1:0])
                                       && r.change_req[$past(r.dp_addr[5:2])]) // RULE5
      else $error("control write lost");
   // [RULE2] only a control write moves a field
   field_stable_a: assert property (!(r.dp_write && r.dp_mapped && r.dp_addr < STATUS_BASE)
                                    |=> r.field == $past(r.field)) // RULE2
      else $error("state field changed without write");
   // [RULE8] the started flag reads back the next cycle
   start_read_a: assert property ((|r.change_req) |=> (started_vec & $past(r.change_req))
                                  == $past(r.change_req)) // RULE8
      else $error("started flag missing after write");
endmodule : switch_partition_state_control

`default_nettype wire

// File: switch_partition_state_control_test.sv
`default_nettype none

module switch_partition_state_control_test;
   import switch_partition_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;

   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   logic hsel;
   logic [31:0] haddr;
   logic [1:0] htrans;
   logic hwrite;
   logic [2:0] hsize;
   logic [31:0] hwdata;
   logic hreadyout;
   logic hresp;
   logic [31:0] hrdata;
   logic [PARTITIONS-1:0] pin_n = '1;
   logic [PARTITIONS-1:0] mode_busy = '0;
   logic [PARTITIONS-1:0] forced_dis;
   logic [PARTITIONS-1:0] part_rst;
   logic [PARTITIONS-1:0] part_act;
   int fail_count = 0;
   int cmp_count = 0;
   int cycles = 0;

   always #(CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;

   switch_partition_state_control i_dut (
      .sys_clk(sys_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .partition_reset_in_n(pin_n), .port_mode_busy(mode_busy),
      .ports_forced_disabled(forced_dis), .partition_reset(part_rst),
      .partition_active(part_act)
   );

   config_master i_master (
      .sys_clk(sys_clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata)
   );

   task automatic close_out;
      $display("checks=%0d mismatches=%0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : close_out

   always @(posedge sys_clk) begin
      cycles++;
      // generous bound: all tests need well under 5000 cycles
      if (cycles == 20000) begin
         fail_count++;
         close_out();
      end
   end

   function automatic logic [31:0] caddr(input int p);
      return {24'h0, CTRL_BASE + 8'(4 * p)};
   endfunction : caddr

   function automatic logic [31:0] saddr(input int p);
      return {24'h0, STATUS_BASE + 8'(4 * p)};
   endfunction : saddr

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
         fail_count++;
      end
   endtask : chk

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] v;
      i_master.xfer(1'b1, a, d, v);
   endtask : wr

   task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
      logic [31:0] v;
      i_master.xfer(1'b0, a, 32'h0, v);
      chk(v, exp);
   endtask : rdc

   // polls status until done, bounded
   task automatic wait_done(input int p);
      logic [31:0] v;
      int n;
      v = '0;
      n = 0;
      while (v[STATUS_DONE_BIT] !== 1'b1 && n < 300) begin
         i_master.xfer(1'b0, saddr(p), 32'h0, v);
         n++;
      end
   endtask : wait_done

   initial begin
      logic [1:0] seq [3];
      logic [1:0] s;
      seq = '{2'h1, 2'h2, 2'h0};
      repeat (2) @(posedge sys_clk);
      resetn <= 1'b1;
      @(posedge sys_clk);
      chk(32'(forced_dis), 32'h0000_ffff);
      chk(32'(part_rst | part_act), 32'h0);
      rdc(saddr(0), 32'h0);
      rdc(saddr(15), 32'h0);
      rdc({24'h0, RESET_DRAIN_OFS}, 32'h0000_09c4);
      rdc({24'h0, MODE_DRAIN_OFS}, 32'h0000_0004);
      rdc(32'h0000_0100, 32'h0);
      // short drain keeps the run brief
      wr({24'h0, RESET_DRAIN_OFS}, 32'h5);
      rdc({24'h0, RESET_DRAIN_OFS}, 32'h5);
      foreach (seq[i]) begin
         s = seq[i];
         wr(caddr(2), 32'(s));
         // started shows one edge after the write lands
         @(posedge sys_clk);
         rdc(saddr(2), 32'({s, 4'h5}));
         wait_done(2);
         rdc(saddr(2), 32'({s, 4'h3}));
         chk(32'({forced_dis[2], part_rst[2], part_act[2]}),
             32'({s == 2'h0, s == 2'h1, s == 2'h2}));
         chk(32'(part_rst[1] | part_act[1]), 32'h0);
      end
      mode_busy[3] <= 1'b1;
      wr(caddr(3), 32'h2);
      repeat (40) @(posedge sys_clk);
      rdc(saddr(3), 32'h0000_0025);
      mode_busy[3] <= 1'b0;
      wait_done(3);
      rdc(saddr(3), 32'h0000_0023);
      wr(saddr(3), 32'h3);
      rdc(saddr(3), 32'h0000_0020);
      wr(caddr(3), 32'h2);
      @(posedge sys_clk);
      rdc(saddr(3), 32'h0000_0025);
      wait_done(3);
      wr(caddr(3), 32'h3);
      rdc(caddr(3), 32'h2);
      rdc(saddr(3), 32'h0000_0023);
      pin_n[5] <= 1'b0;
      repeat (4) @(posedge sys_clk);
      chk(32'(part_rst[5]), 32'h1);
      wr(caddr(5), 32'h2);
      repeat (40) @(posedge sys_clk);
      rdc(saddr(5), 32'h0000_0025);
      chk(32'(part_act[5]), 32'h0);
      pin_n[5] <= 1'b1;
      wait_done(5);
      rdc(saddr(5), 32'h0000_0023);
      chk(32'(part_act[5]), 32'h1);
      wr(caddr(6), 32'h1);
      repeat (30) @(posedge sys_clk);
      chk(32'(part_rst[6]), 32'h1);
      wait_done(6);
      rdc(saddr(6), 32'h0000_0013);
      // loader style: zero timers, change an empty partition, restore
      wr({24'h0, RESET_DRAIN_OFS}, 32'h0);
      wr({24'h0, MODE_DRAIN_OFS}, 32'h0);
      wr(caddr(7), 32'h1);
      wait_done(7);
      rdc(saddr(7), 32'h0000_0013);
      wr({24'h0, RESET_DRAIN_OFS}, 32'(RESET_DRAIN_CYCLES));
      wr({24'h0, MODE_DRAIN_OFS}, 32'(SETTLE_CYCLES));
      rdc({24'h0, RESET_DRAIN_OFS}, 32'h0000_09c4);
      rdc({24'h0, MODE_DRAIN_OFS}, 32'h0000_0004);
      // pin enabled only once configuration is over
      pin_n[7] <= 1'b0;
      repeat (4) @(posedge sys_clk);
      chk(32'(part_rst[7]), 32'h1);
      chk(32'(hresp), 32'h0);
      close_out();
   end
endmodule : switch_partition_state_control_test

`default_nettype wire
